// >>> design/bts_top.sv
/*
 * bts_top: branch trace and debug step logic of one core: breakpoint
 * opcode detection, last-transfer recording, branch-only and per-instruction
 * single stepping, and an Avalon-MM register slave for debugger software.
 * Assumes the retirement and decode inputs come from core logic on ref_clk.
 */
// Contract
// - breakpoint opcode and software interrupt 3 both trap to breakpoint handler.
// - jumps, calls, returns, branches, loops, interrupts, exceptions, system calls count.
// - with record enable set, every control transfer except a debug exception updates the recording registers.
// - branch records its own offset as source and first next instruction as target.
// - interrupt or exception records interrupted offset and handler offset.
// - most interrupts and exceptions copy the branch pair into the exception pair.
// - debug, machine check and emulator break leave the exception pair alone.
// - a debug exception clears record enable.
// - a debug exception leaves all recording registers unchanged.
// - recorded values are segment offsets, not linear addresses.
// - branch-only stepping needs branch step enable and trap flag both set.
// - branch-only stepping raises a debug exception on each branch, interrupt, exception.
// - trap flag alone raises a debug exception after every instruction.
// - a debug exception clears branch step enable and trap flag.
// - a step-caused debug exception sets the single-step status flag.
`timescale 1ns/100ps
`default_nettype none
module bts_top (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic retire_valid,
	input wire logic xfer_valid,
	input wire bts_pkg::bts_xfer_class_e xfer_class,
	input wire bts_pkg::bts_exc_kind_e xfer_exc_kind,
	input wire logic [63:0] xfer_source,
	input wire logic [63:0] xfer_target,
	input wire logic trap_flag_load,
	input wire logic trap_flag_value,
	input wire logic debug_taken,
	input wire logic decode_valid,
	input wire logic [7:0] decode_byte0,
	input wire logic [7:0] decode_byte1,
	output logic debug_exception,
	output logic breakpoint_exception,
	output logic [1:0] breakpoint_length,
	output logic trap_step_flag,
	output logic record_branches_enable
);

	bts_pkg::bts_bus_state_e state_reg, state_next;
	logic waitreq_reg, waitreq_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] read_value;
	logic record_reg, record_next;
	logic bstep_reg, bstep_next;
	logic trap_reg, trap_next;
	logic ss_reg, ss_next;
	logic dbg_reg, dbg_next;
	logic wr_go;
	logic step_hit;
	logic debug_event;
	logic [63:0] bsrc, btgt, esrc, etgt;

	bts_bp_detect u_bp (
		.ref_clk(ref_clk),
		.reset(reset),
		.decode_valid(decode_valid),
		.decode_byte0(decode_byte0),
		.decode_byte1(decode_byte1),
		.breakpoint_exception(breakpoint_exception),
		.breakpoint_length(breakpoint_length)
	);

	// the core reports every kind of control transfer on xfer_valid
	bts_record u_rec (
		.ref_clk(ref_clk),
		.reset(reset),
		.record_enable(record_reg),
		.xfer_valid(xfer_valid),
		.xfer_class(xfer_class),
		.xfer_exc_kind(xfer_exc_kind),
		.xfer_source(xfer_source),
		.xfer_target(xfer_target),
		.branch_source_offset(bsrc),
		.branch_target_offset(btgt),
		.exception_source_offset(esrc),
		.exception_target_offset(etgt)
	);

	// bus: request seen in idle, answered one cycle later with waitrequest low
	always_comb
	begin
		state_next = state_reg;
		rdata_next = rdata_reg;
		case (state_reg)
			bts_pkg::BTS_BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					state_next = bts_pkg::BTS_BUS_ACK;
					rdata_next = avs_read ? read_value : 32'h0;
				end
			end
			bts_pkg::BTS_BUS_ACK:
			begin
				state_next = bts_pkg::BTS_BUS_IDLE;
			end
			default:
			begin
				state_next = bts_pkg::BTS_BUS_IDLE;
			end
		endcase
		waitreq_next = (state_next != bts_pkg::BTS_BUS_ACK);
	end

	// unmapped addresses read as zero and ignore writes
	always_comb
	begin
		read_value = 32'h0;
		if (avs_address == bts_pkg::ADDR_CTRL)
		begin
			read_value[bts_pkg::CTRL_RECORD_BIT] = record_reg;
			read_value[bts_pkg::CTRL_BSTEP_BIT] = bstep_reg;
		end
		else if (avs_address == bts_pkg::ADDR_FLAGS)
			read_value[bts_pkg::FLAGS_TRAP_BIT] = trap_reg;
		else if (avs_address == bts_pkg::ADDR_STATUS)
			read_value[bts_pkg::STATUS_SS_BIT] = ss_reg;
		else if (avs_address == bts_pkg::ADDR_BSRC_LO)
			read_value = bsrc[31:0];
		else if (avs_address == bts_pkg::ADDR_BSRC_HI)
			read_value = bsrc[63:32];
		else if (avs_address == bts_pkg::ADDR_BTGT_LO)
			read_value = btgt[31:0];
		else if (avs_address == bts_pkg::ADDR_BTGT_HI)
			read_value = btgt[63:32];
		else if (avs_address == bts_pkg::ADDR_ESRC_LO)
			read_value = esrc[31:0];
		else if (avs_address == bts_pkg::ADDR_ESRC_HI)
			read_value = esrc[63:32];
		else if (avs_address == bts_pkg::ADDR_ETGT_LO)
			read_value = etgt[31:0];
		else if (avs_address == bts_pkg::ADDR_ETGT_HI)
			read_value = etgt[63:32];
	end

	// writes land on the edge where the master sees waitrequest low
	assign wr_go = avs_write && state_reg == bts_pkg::BTS_BUS_ACK && avs_byteenable[0];

	// in branch-only stepping a debug exception entry itself is never stepped again; trap flag alone steps on any retire_valid
	always_comb
	begin
		step_hit = 1'b0;
		if (trap_reg && bstep_reg)
			step_hit = xfer_valid && xfer_exc_kind != bts_pkg::BTS_EXC_DEBUG;
		else if (trap_reg)
			step_hit = retire_valid;
	end

	assign debug_event = step_hit || debug_taken;

	// control state: software writes, then debug entry clears; the clear
	// wins so the handler never starts with stepping or recording live
	always_comb
	begin
		record_next = record_reg;
		bstep_next = bstep_reg;
		trap_next = trap_reg;
		ss_next = ss_reg;
		dbg_next = step_hit;
		if (wr_go && avs_address == bts_pkg::ADDR_CTRL)
		begin
			record_next = avs_writedata[bts_pkg::CTRL_RECORD_BIT];
			bstep_next = avs_writedata[bts_pkg::CTRL_BSTEP_BIT];
		end
		if (wr_go && avs_address == bts_pkg::ADDR_FLAGS)
			trap_next = avs_writedata[bts_pkg::FLAGS_TRAP_BIT];
		else if (trap_flag_load)
			trap_next = trap_flag_value;
		if (wr_go && avs_address == bts_pkg::ADDR_STATUS
			&& avs_writedata[bts_pkg::STATUS_SS_BIT])
			ss_next = 1'b0;
		if (debug_event)
		begin
			record_next = 1'b0;
			bstep_next = 1'b0;
			trap_next = 1'b0;
		end
		// set wins over a same-cycle clear
		if (step_hit)
			ss_next = 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg <= bts_pkg::BTS_BUS_IDLE;
			waitreq_reg <= 1'b1;
			rdata_reg <= 32'h0;
			record_reg <= bts_pkg::RECORD_RST;
			bstep_reg <= bts_pkg::BSTEP_RST;
			trap_reg <= bts_pkg::TRAP_RST;
			ss_reg <= bts_pkg::SS_STATUS_RST;
			dbg_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			waitreq_reg <= waitreq_next;
			rdata_reg <= rdata_next;
			record_reg <= record_next;
			bstep_reg <= bstep_next;
			trap_reg <= trap_next;
			ss_reg <= ss_next;
			dbg_reg <= dbg_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = waitreq_reg;
	assign debug_exception = dbg_reg;
	assign trap_step_flag = trap_reg;
	assign record_branches_enable = record_reg;

endmodule
`default_nettype wire

// >>> design/bts_pkg.sv
/*
 * bts_pkg: constants and types shared by the branch trace / debug step block.
 * Assumes a 32-bit Avalon-MM register port with byte addresses and 64-bit
 * segment offsets on the retirement interface.
 */
package bts_pkg;

	localparam int OFS_W = 64;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// register byte addresses
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_FLAGS = 6'h04;
	localparam logic [5:0] ADDR_STATUS = 6'h08;
	localparam logic [5:0] ADDR_BSRC_LO = 6'h10;
	localparam logic [5:0] ADDR_BSRC_HI = 6'h14;
	localparam logic [5:0] ADDR_BTGT_LO = 6'h18;
	localparam logic [5:0] ADDR_BTGT_HI = 6'h1c;
	localparam logic [5:0] ADDR_ESRC_LO = 6'h20;
	localparam logic [5:0] ADDR_ESRC_HI = 6'h24;
	localparam logic [5:0] ADDR_ETGT_LO = 6'h28;
	localparam logic [5:0] ADDR_ETGT_HI = 6'h2c;

	// field positions
	localparam int CTRL_RECORD_BIT = 0;
	localparam int CTRL_BSTEP_BIT = 1;
	localparam int FLAGS_TRAP_BIT = 0;
	localparam int STATUS_SS_BIT = 0;

	// reset values
	localparam logic RECORD_RST = 1'b0;
	localparam logic BSTEP_RST = 1'b0;
	localparam logic TRAP_RST = 1'b0;
	localparam logic SS_STATUS_RST = 1'b0;
	localparam logic [63:0] OFS_RST = 64'h0;

	// breakpoint instruction encodings
	localparam logic [7:0] BP_OPCODE = 8'hcc;
	localparam logic [7:0] SWINT_OPCODE = 8'hcd;
	localparam logic [7:0] BP_VECTOR = 8'h03;
	localparam logic [1:0] BP_LEN_SHORT = 2'h1;
	localparam logic [1:0] BP_LEN_LONG = 2'h2;

	typedef enum logic {
		BTS_XFER_BRANCH,
		BTS_XFER_INTR
	} bts_xfer_class_e;

	typedef enum logic [1:0] {
		BTS_EXC_NORMAL,
		BTS_EXC_DEBUG,
		BTS_EXC_MCHECK,
		BTS_EXC_EMUBREAK
	} bts_exc_kind_e;

	typedef enum logic {
		BTS_BUS_IDLE,
		BTS_BUS_ACK
	} bts_bus_state_e;

endpackage

// >>> design/bts_bp_detect.sv
/*
 * bts_bp_detect: spots the one-byte breakpoint opcode and the two-byte
 * software interrupt with vector 3 at decode and requests a breakpoint trap.
 * Assumes decode bytes come from logic on ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module bts_bp_detect (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic decode_valid,
	input wire logic [7:0] decode_byte0,
	input wire logic [7:0] decode_byte1,
	output logic breakpoint_exception,
	output logic [1:0] breakpoint_length
);

	logic bp_reg;
	logic bp_next;
	logic [1:0] len_reg;
	logic [1:0] len_next;

	// both forms go to the breakpoint handler, never the debug handler;
	// the length lets the core push the right return offset
	always_comb
	begin
		bp_next = 1'b0;
		len_next = len_reg;
		if (decode_valid && decode_byte0 == bts_pkg::BP_OPCODE)
		begin
			bp_next = 1'b1;
			len_next = bts_pkg::BP_LEN_SHORT;
		end
		else if (decode_valid && decode_byte0 == bts_pkg::SWINT_OPCODE
			&& decode_byte1 == bts_pkg::BP_VECTOR)
		begin
			bp_next = 1'b1;
			len_next = bts_pkg::BP_LEN_LONG;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			bp_reg <= 1'b0;
			len_reg <= 2'h0;
		end
		else
		begin
			bp_reg <= bp_next;
			len_reg <= len_next;
		end
	end

	assign breakpoint_exception = bp_reg;
	assign breakpoint_length = len_reg;

endmodule
`default_nettype wire

// >>> design/bts_record.sv
/*
 * bts_record: last control transfer and last exception source/target
 * offsets. Assumes one retired transfer per cycle at most, presented in
 * program order by the core.
 */
`timescale 1ns/100ps
`default_nettype none
module bts_record (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic record_enable,
	input wire logic xfer_valid,
	input wire bts_pkg::bts_xfer_class_e xfer_class,
	input wire bts_pkg::bts_exc_kind_e xfer_exc_kind,
	input wire logic [63:0] xfer_source,
	input wire logic [63:0] xfer_target,
	output logic [63:0] branch_source_offset,
	output logic [63:0] branch_target_offset,
	output logic [63:0] exception_source_offset,
	output logic [63:0] exception_target_offset
);

	logic [63:0] bsrc_reg, bsrc_next;
	logic [63:0] btgt_reg, btgt_next;
	logic [63:0] esrc_reg, esrc_next;
	logic [63:0] etgt_reg, etgt_next;
	logic take;

	// only retired transfers arrive here, so the pair is the newest one;
	// a debug exception leaves every recording register alone
	assign take = record_enable && xfer_valid
		&& xfer_exc_kind != bts_pkg::BTS_EXC_DEBUG;

	always_comb
	begin
		bsrc_next = bsrc_reg;
		btgt_next = btgt_reg;
		esrc_next = esrc_reg;
		etgt_next = etgt_reg;
		if (take)
		begin
			// offsets are stored as given, no segment base added
			bsrc_next = xfer_source;
			btgt_next = xfer_target;
			if (xfer_class == bts_pkg::BTS_XFER_INTR
				&& xfer_exc_kind == bts_pkg::BTS_EXC_NORMAL)
			begin
				esrc_next = xfer_source;
				etgt_next = xfer_target;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			bsrc_reg <= bts_pkg::OFS_RST;
			btgt_reg <= bts_pkg::OFS_RST;
			esrc_reg <= bts_pkg::OFS_RST;
			etgt_reg <= bts_pkg::OFS_RST;
		end
		else
		begin
			bsrc_reg <= bsrc_next;
			btgt_reg <= btgt_next;
			esrc_reg <= esrc_next;
			etgt_reg <= etgt_next;
		end
	end

	assign branch_source_offset = bsrc_reg;
	assign branch_target_offset = btgt_reg;
	assign exception_source_offset = esrc_reg;
	assign exception_target_offset = etgt_reg;

endmodule
`default_nettype wire

// >>> tb/bts_chk.sv
/* bts_chk: port-level assertions for bts_top.
   assumes it is bound to bts_top, one clock, synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module bts_chk (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic retire_valid,
	input wire logic xfer_valid,
	input wire bts_pkg::bts_exc_kind_e xfer_exc_kind,
	input wire logic debug_taken,
	input wire logic decode_valid,
	input wire logic [7:0] decode_byte0,
	input wire logic [7:0] decode_byte1,
	input wire logic debug_exception,
	input wire logic breakpoint_exception,
	input wire logic [1:0] breakpoint_length,
	input wire logic trap_step_flag,
	input wire logic record_branches_enable
);
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
wire logic bp1 = decode_valid && decode_byte0 == 8'hcc;
wire logic bp2 = decode_valid && decode_byte0 == 8'hcd && decode_byte1 == 8'h03;
// a normal retired transfer traps in either stepping mode, whatever else happens
wire logic step = retire_valid && xfer_valid && xfer_exc_kind == bts_pkg::BTS_EXC_NORMAL;
a_bp_short: assert property (bp1 |=> breakpoint_exception && breakpoint_length == 2'h1)
	else $error("short breakpoint missed");
a_bp_long: assert property (bp2 |=> breakpoint_exception && breakpoint_length == 2'h2)
	else $error("long breakpoint missed");
a_bp_none: assert property (!(bp1 || bp2) |=> !breakpoint_exception)
	else $error("spurious breakpoint");
a_dbg_clears: assert property (debug_exception |-> !trap_step_flag && !record_branches_enable)
	else $error("enables kept after debug exception");
a_taken_clr: assert property (debug_taken |=> !trap_step_flag && !record_branches_enable)
	else $error("enables kept after debug event");
a_step_fire: assert property (step && trap_step_flag |=> debug_exception)
	else $error("step did not trap");
a_step_cause: assert property (debug_exception |-> $past(trap_step_flag))
	else $error("debug exception without trap flag");
a_bus_ack: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
	else $error("bus request not answered");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/* tb_top: self-checking bench for bts_top against a reference model.
   assumes the design package and bts_chk are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, debug_taken, decode_valid;
logic retire_valid, xfer_valid, trap_flag_load, trap_flag_value, debug_exception;
logic breakpoint_exception, trap_step_flag, record_branches_enable;
logic [5:0] avs_address;
logic [31:0] avs_writedata, avs_readdata, r;
logic [3:0] avs_byteenable;
bts_pkg::bts_xfer_class_e xfer_class;
bts_pkg::bts_exc_kind_e xfer_exc_kind;
logic [63:0] xfer_source, xfer_target;
logic [7:0] decode_byte0, decode_byte1;
logic [1:0] breakpoint_length;
int miscompares = 0;
int samples_checked = 0;
logic [31:0] seed = 32'hd9b5;
logic [63:0] m_bs = 64'h0, m_bt = 64'h0, m_es = 64'h0, m_et = 64'h0;
logic m_rec = 1'b0, m_bsen = 1'b0, m_trap = 1'b0, m_ss = 1'b0;
logic [1:0] m_len = 2'h0;
bts_top i_dut (.*);
initial
begin
	ref_clk = 1'b0;
	forever #2 ref_clk = ~ref_clk;
end
function automatic logic [31:0] xs();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction
task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
	samples_checked++;
	if (seen !== exp)
	begin
		miscompares++;
		$display("mismatch %s expected %h seen %h", nm, exp, seen);
	end
endtask
task print_verdict;
	$display("checked %0d mismatches %0d", samples_checked, miscompares);
	if (miscompares == 0 && samples_checked > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
// holds the request until waitrequest is seen low; no fixed latency assumed
task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
	input logic [3:0] be, output logic [31:0] q);
	int n;
	@(posedge ref_clk);
	avs_address <= a;
	avs_read <= !wr;
	avs_write <= wr;
	avs_writedata <= d;
	avs_byteenable <= be;
	n = 0;
	do
	begin
		@(posedge ref_clk);
		n++;
	end
	while (avs_waitrequest !== 1'b0 && n < 50);
	if (avs_waitrequest !== 1'b0)
	begin
		miscompares++;
		print_verdict();
	end
	q = avs_readdata;
	avs_read <= 1'b0;
	avs_write <= 1'b0;
endtask
task automatic wr(input logic [5:0] a, input logic [31:0] d);
	logic [31:0] q;
	bus(1'b1, a, d, 4'h1, q);
endtask
task automatic rdc(input logic [5:0] a, input logic [31:0] e, input string nm);
	logic [31:0] q;
	bus(1'b0, a, 32'h0, 4'h1, q);
	chk(nm, q, e);
endtask
task automatic rd64(input logic [5:0] a, input logic [63:0] e, input string nm);
	rdc(a, e[31:0], nm);
	rdc(a + 6'h4, e[63:32], nm);
endtask
task automatic regs;
	rdc(6'h00, {30'h0, m_bsen, m_rec}, "ctrl");
	rdc(6'h04, {31'h0, m_trap}, "flags");
	rdc(6'h08, {31'h0, m_ss}, "status");
	rd64(6'h10, m_bs, "bsrc");
	rd64(6'h18, m_bt, "btgt");
	rd64(6'h20, m_es, "esrc");
	rd64(6'h28, m_et, "etgt");
endtask
task automatic setc(input logic rec, input logic bsen);
	wr(6'h00, {30'h0, bsen, rec});
	m_rec = rec;
	m_bsen = bsen;
endtask
task automatic bp(input logic [7:0] b0, input logic [7:0] b1);
	logic hit;
	hit = b0 == 8'hcc || (b0 == 8'hcd && b1 == 8'h03);
	if (hit)
		m_len = b0 == 8'hcc ? 2'h1 : 2'h2;
	@(posedge ref_clk);
	decode_valid <= 1'b1;
	decode_byte0 <= b0;
	decode_byte1 <= b1;
	@(posedge ref_clk);
	decode_valid <= 1'b0;
	#1;
	chk("bp", breakpoint_exception, hit);
	chk("len", breakpoint_length, m_len);
endtask
task automatic ev(input logic rv, input logic xv, input logic cls, input logic [1:0] k,
	input logic dt);
	logic hit;
	logic [63:0] s, t;
	s = {xs(), xs()};
	t = {xs(), xs()};
	hit = m_trap && (m_bsen ? xv && k != 2'h1 : rv);
	@(posedge ref_clk);
	retire_valid <= rv;
	xfer_valid <= xv;
	xfer_class <= bts_pkg::bts_xfer_class_e'(cls);
	xfer_exc_kind <= bts_pkg::bts_exc_kind_e'(k);
	xfer_source <= s;
	xfer_target <= t;
	debug_taken <= dt;
	@(posedge ref_clk);
	retire_valid <= 1'b0;
	xfer_valid <= 1'b0;
	debug_taken <= 1'b0;
	if (xv && m_rec && k != 2'h1)
	begin
		m_bs = s;
		m_bt = t;
		if (cls && k == 2'h0)
		begin
			m_es = s;
			m_et = t;
		end
	end
	if (hit || dt)
	begin
		m_rec = 1'b0;
		m_bsen = 1'b0;
		m_trap = 1'b0;
	end
	if (hit)
		m_ss = 1'b1;
	#1;
	chk("step", debug_exception, hit);
	chk("trap", trap_step_flag, m_trap);
	chk("rec", record_branches_enable, m_rec);
endtask
initial
begin
	repeat (40000) @(posedge ref_clk);
	miscompares++;
	print_verdict();
end
initial
begin
	{avs_read, avs_write, retire_valid, xfer_valid, trap_flag_load} = 5'h0;
	{trap_flag_value, debug_taken, decode_valid, decode_byte0, decode_byte1} = 19'h0;
	{avs_address, avs_writedata, avs_byteenable, xfer_source, xfer_target} = 170'h0;
	xfer_class = bts_pkg::BTS_XFER_BRANCH;
	xfer_exc_kind = bts_pkg::BTS_EXC_NORMAL;
	reset = 1'b1;
	repeat (6) @(posedge ref_clk);
	reset <= 1'b0;
	regs();
	rdc(6'h3c, 32'h0, "unmapped");
	wr(6'h10, 32'hffffffff);
	rdc(6'h10, 32'h0, "ro");
	bus(1'b1, 6'h00, 32'h3, 4'h0, r);
	rdc(6'h00, 32'h0, "be0");
	bp(8'hcc, 8'h00);
	bp(8'h8b, 8'h45);
	bp(8'hcd, 8'h03);
	bp(8'hcd, 8'h04);
	repeat (30)
	begin
		r = xs();
		bp({6'h33, r[1:0]}, r[2] ? 8'h03 : r[15:8]);
	end
	setc(1'b1, 1'b0);
	repeat (20)
	begin
		r = xs();
		ev(1'b1, 1'b1, r[0], r[2:1], r[2:1] == 2'h1);
		regs();
		if (!m_rec)
			setc(1'b1, 1'b0);
	end
	setc(1'b0, 1'b0);
	ev(1'b1, 1'b1, 1'b1, 2'h0, 1'b0);
	regs();
	setc(1'b1, 1'b1);
	wr(6'h04, 32'h1);
	m_trap = 1'b1;
	ev(1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
	ev(1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
	regs();
	wr(6'h08, 32'h1);
	m_ss = 1'b0;
	setc(1'b0, 1'b1);
	ev(1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
	wr(6'h04, 32'h1);
	m_trap = 1'b1;
	ev(1'b0, 1'b1, 1'b1, 2'h0, 1'b0);
	@(posedge ref_clk);
	trap_flag_load <= 1'b1;
	trap_flag_value <= 1'b1;
	@(posedge ref_clk);
	trap_flag_load <= 1'b0;
	m_trap = 1'b1;
	ev(1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
	regs();
	setc(1'b1, 1'b0);
	ev(1'b0, 1'b0, 1'b0, 2'h0, 1'b1);
	regs();
	print_verdict();
end
endmodule
bind bts_top bts_chk i_chk (.*);
`default_nettype wire
